// file: design/rmpu_unit.v
// Region memory protection unit: registers and access checker
// Operation
// [R01] Eight regions, 0 to 7, each with base/size entry and select entry.
// [R02] Each region splits into sixteen equal subregions.
// [R03] Select bit 0 picks permission set A, 1 picks set B.
// [R04] Hit subregion's select bit picks A or B permission and attributes.
// [R05] Insufficient privilege raises an exception and aborts the access.
// [R06] Address outside all valid regions aborts and raises an exception.
// [R07] Addresses pass through unchanged; no translation.
// [R08] Size code 01011 is 4 KB, doubling per step to 4 GB.
// [R09] Base entry holds bits 31:12; low twelve bits read as zero. Only bits 11:6 read zero here; 5:0 return size and valid.
// [R10] Software aligns each base to its region size.
// [R11] Regions with valid clear take no part in hit detection.
// [R12] Reset clears every region valid bit.
// [R13] Reset clears protection enable; checking starts once software sets it.
// [R14] Disabled unit reports uncacheable, unbufferable, and never faults.
// [R15] Software defines a valid region before enabling protection.
// [R16] Cacheable registers A and B, one bit per region, reset zero.
// [R17] Bufferable registers A and B, one bit per region, reset zero.
// [R18] Attribute registers are optional, selected by a parameter.
// [R19] Configuration register field reports the number of regions.
// [R20] Four-bit permission code grants privileged and unprivileged rights.
// [R21] Fetch and data faults are told apart; failing address is reported.
// [R22] A hit in several valid regions raises a multiple-hit violation.
// [R23] Compare bits above size boundary; next four bits index the subregion.
`include "rmpu_defines.vh"
module rmpu_unit #(
  parameter REGIONS    = 8,
  parameter HAS_ATTRIB = 1
) (
  input  wire        core_clk_in,
  input  wire        rst_in,
  input  wire        sr_wr_in,
  input  wire [4:0]  sr_sel_in,
  input  wire [2:0]  sr_idx_in,
  input  wire [31:0] sr_wdata_in,
  output reg  [31:0] sr_rdata_out,
  input  wire        acc_valid_in,
  input  wire [31:0] acc_addr_in,
  input  wire        acc_fetch_in,
  input  wire        acc_write_in,
  input  wire        acc_priv_in,
  output reg         acc_done_out,
  output reg  [31:0] acc_addr_out,
  output reg         acc_abort_out,
  output reg  [2:0]  acc_exc_out,
  output reg  [31:0] acc_fail_addr_out,
  output reg         acc_cacheable_out,
  output reg         acc_bufferable_out
);

  // Per-region storage; low base bits are never stored
  reg [19:0] base    [0:REGIONS-1]; // R09
  reg [4:0]  size    [0:REGIONS-1];
  reg [REGIONS-1:0] valid;
  reg [15:0] psel    [0:REGIONS-1]; // R01
  reg [31:0] perm_a;
  reg [31:0] perm_b;
  reg [REGIONS-1:0] cache_a;
  reg [REGIONS-1:0] cache_b;
  reg [REGIONS-1:0] buf_a;
  reg [REGIONS-1:0] buf_b;
  reg        prot_en;

  integer i;

  // System register writes
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      valid   <= {REGIONS{1'b0}}; // R12
      prot_en <= 1'b0; // R13
      perm_a  <= `RMPU_ZERO32;
      perm_b  <= `RMPU_ZERO32;
      cache_a <= {REGIONS{1'b0}}; // R16
      cache_b <= {REGIONS{1'b0}};
      buf_a   <= {REGIONS{1'b0}}; // R17
      buf_b   <= {REGIONS{1'b0}};
      for (i = 0; i < REGIONS; i = i + 1) begin
        base[i] <= 20'h00000;
        size[i] <= `RMPU_SIZE_MIN;
        psel[i] <= 16'h0000;
      end
    end else if (sr_wr_in) begin
      case (sr_sel_in)
        `RMPU_SEL_BSV: begin
          base[sr_idx_in]  <= sr_wdata_in[`RMPU_BASE_HI:`RMPU_BASE_LO];
          size[sr_idx_in]  <= sr_wdata_in[`RMPU_SIZE_HI:`RMPU_SIZE_LO];
          valid[sr_idx_in] <= sr_wdata_in[`RMPU_VALID_BIT];
        end
        `RMPU_SEL_PSEL:   psel[sr_idx_in] <= sr_wdata_in[15:0];
        `RMPU_SEL_PERM_A: perm_a <= sr_wdata_in;
        `RMPU_SEL_PERM_B: perm_b <= sr_wdata_in;
        // Without attribute storage these bits stay zero
        `RMPU_SEL_CACHE_A: if (HAS_ATTRIB != 0) cache_a <= sr_wdata_in[REGIONS-1:0]; // R18
        `RMPU_SEL_CACHE_B: if (HAS_ATTRIB != 0) cache_b <= sr_wdata_in[REGIONS-1:0];
        `RMPU_SEL_BUF_A:   if (HAS_ATTRIB != 0) buf_a <= sr_wdata_in[REGIONS-1:0];
        `RMPU_SEL_BUF_B:   if (HAS_ATTRIB != 0) buf_b <= sr_wdata_in[REGIONS-1:0];
        `RMPU_SEL_CTRL:    prot_en <= sr_wdata_in[0];
        default: ;
      endcase
    end
  end

  // Read mux, registered so the output comes from a flop
  localparam [3:0] REGION_COUNT = REGIONS;
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = `RMPU_ZERO32;
    case (sr_sel_in)
      `RMPU_SEL_BSV: next_rdata = {base[sr_idx_in], 6'h00, size[sr_idx_in],
                                   valid[sr_idx_in]}; // R09
      `RMPU_SEL_PSEL:    next_rdata = {16'h0000, psel[sr_idx_in]};
      `RMPU_SEL_PERM_A:  next_rdata = perm_a;
      `RMPU_SEL_PERM_B:  next_rdata = perm_b;
      `RMPU_SEL_CACHE_A: next_rdata[REGIONS-1:0] = cache_a;
      `RMPU_SEL_CACHE_B: next_rdata[REGIONS-1:0] = cache_b;
      `RMPU_SEL_BUF_A:   next_rdata[REGIONS-1:0] = buf_a;
      `RMPU_SEL_BUF_B:   next_rdata[REGIONS-1:0] = buf_b;
      `RMPU_SEL_CTRL:    next_rdata[0] = prot_en;
      `RMPU_SEL_CONFIG:  next_rdata[`RMPU_CFG_COUNT_LO+3:`RMPU_CFG_COUNT_LO] = REGION_COUNT; // R19
      default:           next_rdata = `RMPU_ZERO32;
    endcase
  end

  // Hit detection per region
  reg [REGIONS-1:0] hit;
  reg [3:0]         sub_idx [0:REGIONS-1];
  reg [31:0]        mask;
  reg [31:0]        sub_w;
  reg [5:0]         shamt;
  integer           r;
  always @* begin
    mask = `RMPU_ZERO32;
    sub_w = `RMPU_ZERO32;
    shamt = 6'h00;
    for (r = 0; r < REGIONS; r = r + 1) begin
      // Codes below 4 KB are undefined; treat them as 4 KB
      if (size[r] < `RMPU_SIZE_MIN)
        shamt = {1'b0, `RMPU_SIZE_MIN} + 6'h01;
      else
        shamt = {1'b0, size[r]} + 6'h01; // R08
      // Six bits wide so the 4 GB code shifts the whole mask out
      mask = 32'hffff_ffff << shamt;
      // Compare above the boundary only, so misaligned bits are ignored
      hit[r] = valid[r] & ((acc_addr_in & mask) ==
               ({base[r], 12'h000} & mask)); // R11 R23
      sub_w = acc_addr_in >> (shamt - `RMPU_SUB_BITS); // R02
      sub_idx[r] = sub_w[3:0]; // R23
    end
  end

  // Select the single hitting region and its permission set
  reg [2:0] hit_n;
  reg [3:0] hit_cnt;
  reg       sel_b;
  reg [3:0] ap;
  reg       att_c;
  reg       att_b;
  reg [15:0] ps;
  always @* begin
    hit_n = 3'h0;
    hit_cnt = 4'h0;
    for (r = 0; r < REGIONS; r = r + 1) begin
      if (hit[r]) begin
        hit_n = r[2:0];
        hit_cnt = hit_cnt + 4'h1;
      end
    end
    ps = psel[hit_n];
    sel_b = ps[sub_idx[hit_n]]; // R03 R04
    ap = sel_b ? perm_b[hit_n*4 +: 4] : perm_a[hit_n*4 +: 4];
    att_c = sel_b ? cache_b[hit_n] : cache_a[hit_n]; // R04
    att_b = sel_b ? buf_b[hit_n] : buf_a[hit_n];
  end

  // Permission decode: privileged and unprivileged read/write/execute
  reg p_r;
  reg p_w;
  reg p_x;
  reg u_r;
  reg u_w;
  reg u_x;
  always @* begin
    {p_r, p_w, p_x, u_r, u_w, u_x} = 6'b000000;
    case (ap) // R20
      4'h0: {p_r, p_w, p_x, u_r, u_w, u_x} = 6'b100000;
      4'h1: {p_r, p_w, p_x, u_r, u_w, u_x} = 6'b101000;
      4'h2: {p_r, p_w, p_x, u_r, u_w, u_x} = 6'b110000;
      4'h3: {p_r, p_w, p_x, u_r, u_w, u_x} = 6'b111000;
      4'h4: {p_r, p_w, p_x, u_r, u_w, u_x} = 6'b100100;
      4'h5: {p_r, p_w, p_x, u_r, u_w, u_x} = 6'b101101;
      4'h6: {p_r, p_w, p_x, u_r, u_w, u_x} = 6'b110110;
      4'h7: {p_r, p_w, p_x, u_r, u_w, u_x} = 6'b111111;
      4'h8: {p_r, p_w, p_x, u_r, u_w, u_x} = 6'b110100;
      4'h9: {p_r, p_w, p_x, u_r, u_w, u_x} = 6'b110101;
      // Undefined codes deny, the safe reading
      default: {p_r, p_w, p_x, u_r, u_w, u_x} = 6'b000000;
    endcase
  end

  // Access verdict
  reg       allowed;
  reg [2:0] next_exc;
  always @* begin
    if (acc_fetch_in)
      allowed = acc_priv_in ? p_x : u_x;
    else if (acc_write_in)
      allowed = acc_priv_in ? p_w : u_w;
    else
      allowed = acc_priv_in ? p_r : u_r;
    if (!prot_en)
      next_exc = `RMPU_EXC_NONE; // R14
    else if (hit_cnt > 4'h1)
      next_exc = `RMPU_EXC_MULTI; // R22
    else if (hit_cnt == 4'h0)
      next_exc = acc_fetch_in ? `RMPU_EXC_IMISS : `RMPU_EXC_DMISS; // R06 R21
    else if (!allowed)
      next_exc = acc_fetch_in ? `RMPU_EXC_IPROT : `RMPU_EXC_DPROT; // R05 R21
    else
      next_exc = `RMPU_EXC_NONE;
  end

  // Registered answer one cycle after the access
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      sr_rdata_out       <= `RMPU_ZERO32;
      acc_done_out       <= 1'b0;
      acc_addr_out       <= `RMPU_ZERO32;
      acc_abort_out      <= 1'b0;
      acc_exc_out        <= `RMPU_EXC_NONE;
      acc_fail_addr_out  <= `RMPU_ZERO32;
      acc_cacheable_out  <= 1'b0;
      acc_bufferable_out <= 1'b0;
    end else begin
      sr_rdata_out  <= next_rdata;
      acc_done_out  <= acc_valid_in;
      acc_addr_out  <= acc_addr_in; // R07
      acc_abort_out <= acc_valid_in & (next_exc != `RMPU_EXC_NONE); // R05 R06
      acc_exc_out   <= acc_valid_in ? next_exc : `RMPU_EXC_NONE;
      if (acc_valid_in && next_exc != `RMPU_EXC_NONE)
        acc_fail_addr_out <= acc_addr_in; // R21
      acc_cacheable_out  <= acc_valid_in & prot_en & (hit_cnt == 4'h1) & att_c; // R14
      acc_bufferable_out <= acc_valid_in & prot_en & (hit_cnt == 4'h1) & att_b;
    end
  end

endmodule // rmpu_unit

// file: design/rmpu_defines.vh
// Constants for the region memory protection unit
`ifndef RMPU_DEFINES_VH
`define RMPU_DEFINES_VH
// System register selectors
`define RMPU_SEL_W          5
`define RMPU_SEL_BSV        5'h00
`define RMPU_SEL_PSEL       5'h08
`define RMPU_SEL_PERM_A     5'h10
`define RMPU_SEL_PERM_B     5'h11
`define RMPU_SEL_CACHE_A    5'h12
`define RMPU_SEL_CACHE_B    5'h13
`define RMPU_SEL_BUF_A      5'h14
`define RMPU_SEL_BUF_B      5'h15
`define RMPU_SEL_CTRL       5'h16
`define RMPU_SEL_CONFIG     5'h17
// Region base/size/valid fields
`define RMPU_BASE_HI        31
`define RMPU_BASE_LO        12
`define RMPU_SIZE_HI        5
`define RMPU_SIZE_LO        1
`define RMPU_VALID_BIT      0
`define RMPU_SIZE_MIN       5'h0b
`define RMPU_SUB_BITS       4
// Permission code
`define RMPU_AP_W           4
`define RMPU_CFG_COUNT_LO   0
// Violation codes
`define RMPU_EXC_NONE       3'h0
`define RMPU_EXC_IPROT      3'h1
`define RMPU_EXC_DPROT      3'h2
`define RMPU_EXC_IMISS      3'h3
`define RMPU_EXC_DMISS      3'h4
`define RMPU_EXC_MULTI      3'h5
`define RMPU_ZERO32         32'h0000_0000
`endif

// file: dv/rmpu_pipe_model.sv
// Pipeline stage model issuing accesses to the unit
module rmpu_pipe_model (
  input  wire        clk_in,
  input  wire        go_in,
  input  wire [34:0] req_in,
  output reg         valid_out = 1'b0,
  output reg  [34:0] req_out = 35'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle lines toggle so a stale address never looks valid
  always @(posedge clk_in) begin
    valid_out <= go_in;
    req_out   <= go_in ? req_in : ~req_out;
  end
endmodule // rmpu_pipe_model

// file: dv/rmpu_monitor.sv
// Port assertions for the region protection unit
`include "rmpu_defines.vh"
module rmpu_monitor #(parameter REGIONS = 8) (
  input wire        core_clk_in, rst_in, sr_wr_in, acc_valid_in, acc_fetch_in,
  input wire        acc_done_out, acc_abort_out, acc_cacheable_out, acc_bufferable_out,
  input wire [4:0]  sr_sel_in,
  input wire [2:0]  acc_exc_out,
  input wire [31:0] sr_wdata_in, sr_rdata_out, acc_addr_in, acc_addr_out, acc_fail_addr_out
);
  reg en = 1'b0;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Enable shadow; a write applies from the next access on
  always @(posedge core_clk_in)
    en <= rst_in ? 1'b0 : (sr_wr_in && sr_sel_in == `RMPU_SEL_CTRL) ? sr_wdata_in[0] : en;
  sequence acc_s;
    acc_valid_in ##1 acc_done_out;
  endsequence
  done_lat_a: assert property (acc_valid_in |=> acc_done_out)
    else $error("verdict missing");
  no_spur_a: assert property (!acc_valid_in |=> !acc_done_out)
    else $error("verdict without request");
  addr_pass_a: assert property (acc_s |-> acc_addr_out == $past(acc_addr_in))
    else $error("address altered");
  abort_code_a: assert property (acc_done_out |-> acc_abort_out == (acc_exc_out != 0))
    else $error("abort and code disagree");
  off_quiet_a: assert property (acc_valid_in && !en |=> !acc_abort_out
    && !acc_cacheable_out && !acc_bufferable_out) else $error("disabled unit acted");
  fetch_code_a: assert property (acc_valid_in && acc_fetch_in |=> acc_exc_out inside {0, 1, 3, 5})
    else $error("fetch got data code");
  data_code_a: assert property (acc_valid_in && !acc_fetch_in |=> acc_exc_out inside {0, 2, 4, 5})
    else $error("data got fetch code");
  miss_attr_a: assert property (acc_done_out && acc_exc_out > 2 |-> !acc_cacheable_out)
    else $error("attribute on miss");
  fail_set_a: assert property (acc_abort_out |-> acc_fail_addr_out == acc_addr_out)
    else $error("fault address not kept");
  fail_hold_a: assert property (!acc_abort_out |-> $stable(acc_fail_addr_out))
    else $error("fault address moved");
  count_a: assert property (sr_sel_in == `RMPU_SEL_CONFIG |=> sr_rdata_out[3:0] == 4'(REGIONS))
    else $error("region count wrong");
endmodule // rmpu_monitor
bind rmpu_unit rmpu_monitor #(.REGIONS(REGIONS)) u_rmpu_monitor (.*);

// file: dv/rmpu_unit_bench.sv
// Self-checking bench for the region protection unit
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module rmpu_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 0, rst_in = 1, sr_wr_in = 0, go = 0, acc_done_out, acc_abort_out;
  logic [4:0] sr_sel_in = 0;
  logic [2:0] sr_idx_in = 0, acc_exc_out;
  logic [31:0] sr_wdata_in = 0, sr_rdata_out, acc_addr_out, acc_fail_addr_out, d;
  logic [34:0] req = 0;
  logic acc_cacheable_out, acc_bufferable_out, en = 0;
  wire acc_valid_in, acc_fetch_in, acc_write_in, acc_priv_in;
  wire [31:0] acc_addr_in;
  logic [31:0] bs [8] = '{default: 32'h16}, ps [8] = '{default: 0};
  logic [31:0] pa = 0, pb = 0, ca = 0, cb = 0, ba = 0, bb = 0;
  logic [37:0] q [$], e;
  int failures = 0, checked = 0, n, sz;
  rmpu_unit u_rmpu_unit (.core_clk_in, .rst_in, .sr_wr_in, .sr_sel_in, .sr_idx_in,
    .sr_wdata_in, .sr_rdata_out, .acc_valid_in, .acc_addr_in, .acc_fetch_in, .acc_write_in,
    .acc_priv_in, .acc_done_out, .acc_addr_out, .acc_abort_out, .acc_exc_out,
    .acc_fail_addr_out, .acc_cacheable_out, .acc_bufferable_out);
  rmpu_pipe_model u_rmpu_pipe_model (.clk_in(core_clk_in), .go_in(go), .req_in(req),
    .valid_out(acc_valid_in), .req_out({acc_fetch_in, acc_write_in, acc_priv_in, acc_addr_in}));
  initial forever #10 core_clk_in = ~core_clk_in;
  // Reference verdict: {address, code, attributes checked, cacheable, bufferable}
  function automatic logic [37:0] model(logic [34:0] r);
    int h, sh;
    logic s, k, b;
    logic [3:0] c;
    logic [2:0] x;
    logic [15:0] m;
    h = 0; k = 0; b = 0; c = 0; x = 0;
    for (int j = 0; j < 8; j++) begin
      sh = (bs[j][5:1] < 11 ? 11 : bs[j][5:1]) + 1;
      if (bs[j][0] && (r[31:0] >> sh) == (bs[j] >> sh)) begin
        h++;
        s = ps[j][(r[31:0] >> (sh - 4)) & 15];
        c = s ? pb[4*j+:4] : pa[4*j+:4];
        k = s ? cb[j] : ca[j];
        b = s ? bb[j] : ba[j];
      end
    end
    m = r[34] ? (r[32] ? 16'h00aa : 16'h02a0) : r[33] ? (r[32] ? 16'h03cc : 16'h00c0)
      : (r[32] ? 16'h03ff : 16'h03f0);
    if (!en) x = 0;
    else if (h > 1) x = 5;
    else if (h == 0) x = r[34] ? 3 : 4;
    else if (!m[c]) x = r[34] ? 1 : 2;
    s = en && h == 1 && x == 0;
    return {r[31:0], x, x != 1 && x != 2, s & k, s & b};
  endfunction
  // Each verdict is matched with the oldest outstanding request
  always @(negedge core_clk_in) if (acc_done_out === 1'b1) begin
    e = q.pop_front();
    `CHK("addr", e[37:6], acc_addr_out)
    `CHK("code", e[5:3], acc_exc_out)
    `CHK("abort", e[5:3] != 0, acc_abort_out)
    if (e[2]) `CHK("attr", e[1:0], {acc_cacheable_out, acc_bufferable_out})
    if (e[5:3] != 0) `CHK("fail", e[37:6], acc_fail_addr_out)
  end
  task automatic wreg(logic [4:0] s, logic [2:0] x, logic [31:0] v);
    @(posedge core_clk_in);
    sr_wr_in <= 1; sr_sel_in <= s; sr_idx_in <= x; sr_wdata_in <= v;
    @(posedge core_clk_in);
    sr_wr_in <= 0;
    case (s)
      0: bs[x] = v & 32'hfffff03f; 8: ps[x] = v; 5'h10: pa = v; 5'h11: pb = v;
      5'h12: ca = v; 5'h13: cb = v; 5'h14: ba = v; 5'h15: bb = v; 5'h16: en = v[0];
    endcase
  endtask
  task automatic rreg(logic [4:0] s, logic [2:0] x, logic [31:0] v);
    @(posedge core_clk_in);
    sr_sel_in <= s; sr_idx_in <= x;
    @(posedge core_clk_in);
    #1 `CHK("reg", v, sr_rdata_out)
  endtask
  // Back-to-back random accesses, then a bounded drain
  task automatic issue(int cnt);
    logic [34:0] t;
    repeat (cnt) begin
      @(posedge core_clk_in);
      go <= 1;
      t = {$urandom % 8, $urandom & 32'h001fffff};
      req <= t;
      q.push_back(model(t));
    end
    @(posedge core_clk_in);
    go <= 0;
    n = 0;
    while (q.size() && n < 10) begin @(posedge core_clk_in); n++; end
    if (q.size()) begin failures++; give_verdict(); end
  endtask
  task automatic give_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h589a));
    repeat (4) @(posedge core_clk_in);
    rst_in <= 0;
    rreg(0, 3, 32'h16);
    rreg(8, 3, 0);
    for (int i = 16; i < 23; i++) rreg(i, 0, 0);
    rreg(5'h17, 0, 8);
    rreg(5'h1f, 0, 0);
    issue(20);
    for (int r = 0; r < 5; r++) begin
      for (int j = 0; j < 8; j++) begin
        sz = 11 + $urandom % 8;
        d = ($urandom & 32'h001ff000) & ~((32'h2 << sz) - 1);
        d = d | sz << 1 | (j == 0 || $urandom % 4 != 0);
        wreg(0, j, d | ($urandom & 32'h0fc0));
        rreg(0, j, d);
        wreg(8, j, $urandom);
      end
      for (int i = 16; i < 22; i++) wreg(i, 0, $urandom);
      wreg(5'h16, 0, r < 4);
      issue(60);
    end
    give_verdict();
  end
endmodule // rmpu_unit_bench
